// ---- rtl/rsag_pkg.sv ----
package rsag_pkg;

  localparam int REG_AW = 2;
  localparam int REG_DW = 16;
  localparam int LBUS_W = 16;

  // Register offsets on the plain register port.
  localparam logic [REG_AW-1:0] ADDR_COUNTER_OFS = 2'h0;
  localparam logic [REG_AW-1:0] CTRL_OFS         = 2'h1;
  localparam logic [REG_AW-1:0] FRAME_START_OFS  = 2'h2;
  localparam logic [REG_AW-1:0] PAN_TAP_OFS      = 2'h3;

  // Reset values.
  localparam logic [REG_DW-1:0] ADDR_COUNTER_RST = 16'h0000;
  localparam logic [REG_DW-1:0] CTRL_RST         = 16'h0000;
  localparam logic [REG_DW-1:0] FRAME_START_RST  = 16'h0000;
  localparam logic [REG_DW-1:0] PAN_TAP_RST      = 16'h0000;

  // Field positions.
  localparam int CNT_LSB    = 2;
  localparam int CNT_W      = 14;
  localparam int STEP_LSB   = 2;
  localparam int STEP_W     = 8;
  localparam int ORIGIN_BIT = 10;
  localparam int NONINT_BIT = 11;
  localparam int TAP_W      = 14;

  // Status lines of the local bus during the two address phases.
  localparam logic [3:0] ROW_STATUS = 4'h8;
  localparam logic [1:0] COL_STATUS = 2'h0;

  typedef enum {
    RSAG_IDLE,
    RSAG_REQ,
    RSAG_ROW,
    RSAG_COL
  } rsag_state_type;

endpackage

// ---- rtl/rsag_addr_if.sv ----
`timescale 1ns/10ps
`default_nettype none

interface rsag_addr_if;
  import rsag_pkg::*;
  logic [CNT_W-1:0]  counter;
  logic              origin_select;
  logic [TAP_W-1:0]  pan_tap;
  logic [LBUS_W-1:0] row_word;
  logic [LBUS_W-1:0] col_word;

  modport fmt (
    input  counter,
    input  origin_select,
    input  pan_tap,
    output row_word,
    output col_word
  );

  modport ctl (
    output counter,
    output origin_select,
    output pan_tap,
    input  row_word,
    input  col_word
  );
endinterface

`default_nettype wire

// ---- rtl/rsag_addr_fmt.sv ----
`timescale 1ns/10ps
`default_nettype none

module rsag_addr_fmt (
  rsag_addr_if.fmt af
);
  import rsag_pkg::*;

  wire logic [CNT_W-1:0] shown;
  wire logic [5:0]       merged;

  // The counter is shown inverted when the origin is top left.
  assign shown = af.origin_select ? af.counter : ~af.counter;
  // Row word: counter bits 2-13 low, status lines above.
  assign af.row_word = {ROW_STATUS, shown[CNT_W-1:2]};
  // Column word: pan tap merged with the low counter bits.
  assign merged = af.pan_tap[11:6] | shown[5:0];
  assign af.col_word = {COL_STATUS, af.pan_tap[13:12],
                        merged, af.pan_tap[5:0]};

endmodule

`default_nettype wire

// ---- rtl/rsag_req_track.sv ----
`timescale 1ns/10ps
`default_nettype none

module rsag_req_track (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic hblank_start,
  input  wire logic vblank,
  input  wire logic first_line_next,
  input  wire logic done,
  output logic      pending
);
  logic pend_ff;
  wire logic raise;

  // No request in vertical blanking except before the first line.
  assign raise = hblank_start && (!vblank || first_line_next);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_ff <= 1'b0;
    end else begin
      pend_ff <= raise | (pend_ff & ~done);
    end
  end

  assign pending = pend_ff;

endmodule

`default_nettype wire

// ---- rtl/rsag_refresh_addr_gen.sv ----
`timescale 1ns/10ps
`default_nettype none

module rsag_refresh_addr_gen (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic [rsag_pkg::REG_AW-1:0] reg_addr,
  input  wire logic [rsag_pkg::REG_DW-1:0] reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [rsag_pkg::REG_DW-1:0] reg_rdata,
  input  wire logic                        hblank_start,
  input  wire logic                        frame_end,
  input  wire logic                        vblank,
  input  wire logic                        first_line_next,
  input  wire logic                        even_field,
  input  wire logic                        bus_grant,
  input  wire logic                        bus_hold,
  output logic                             srf_req,
  output logic                             row_phase,
  output logic                             col_phase,
  output logic      [rsag_pkg::LBUS_W-1:0] local_bus_out,
  output logic                             local_bus_oe
);
  import rsag_pkg::*;

  logic                 rst_meta_ff;
  logic                 rst_sync_ff;
  logic [REG_DW-1:0]    addr_cnt_ff;
  logic [REG_DW-1:0]    ctrl_ff;
  logic [REG_DW-1:0]    start_ff;
  logic [REG_DW-1:0]    tap_ff;
  logic [REG_DW-1:0]    rdata_ff;
  logic [LBUS_W-1:0]    bus_word_ff;
  logic                 bus_oe_ff;
  rsag_state_type       state_ff;
  rsag_state_type       nxt_state;
  logic [REG_DW-1:0]    nxt_addr_cnt;

  wire logic [CNT_W-1:0]  cnt;
  wire logic [STEP_W-1:0] step;
  wire logic [CNT_W-1:0]  step_ext;
  wire logic [CNT_W-1:0]  half_ext;
  wire logic [CNT_W-1:0]  reload_val;
  wire logic [CNT_W-1:0]  stepped_val;
  wire logic              origin_sel;
  wire logic              nonint_sel;
  wire logic              reload;
  wire logic              start_go;
  wire logic              done;
  wire logic              pending;
  wire logic              wr_cnt;
  wire logic              wr_ctrl;
  wire logic              wr_start;
  wire logic              wr_tap;
  wire logic [REG_DW-1:0] rd_mux;

  rsag_addr_if af ();

  // Reset release through two flip-flops.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Field decode.
  assign cnt        = addr_cnt_ff[CNT_LSB +: CNT_W];
  assign step       = ctrl_ff[STEP_LSB +: STEP_W];
  assign origin_sel = ctrl_ff[ORIGIN_BIT];
  assign nonint_sel = ctrl_ff[NONINT_BIT];
  assign step_ext   = {{(CNT_W-STEP_W){1'b0}}, step};
  assign half_ext   = {{(CNT_W-STEP_W+1){1'b0}}, step[STEP_W-1:1]};

  // Frame reload, with the half step at an even interlaced field.
  assign reload = hblank_start && frame_end;
  assign reload_val = start_ff[CNT_LSB +: CNT_W] +
                      ((!nonint_sel && even_field) ?
                       half_ext : {CNT_W{1'b0}});
  // Line step after the column phase.
  assign stepped_val = cnt - step_ext;

  // Register write decode.
  assign wr_cnt   = reg_wr && (reg_addr == ADDR_COUNTER_OFS);
  assign wr_ctrl  = reg_wr && (reg_addr == CTRL_OFS);
  assign wr_start = reg_wr && (reg_addr == FRAME_START_OFS);
  assign wr_tap   = reg_wr && (reg_addr == PAN_TAP_OFS);

  assign rd_mux = (reg_addr == ADDR_COUNTER_OFS) ? addr_cnt_ff :
                  (reg_addr == CTRL_OFS)         ? ctrl_ff :
                  (reg_addr == FRAME_START_OFS)  ? start_ff :
                                                   tap_ff;

  // Sequencer handshakes.
  assign start_go = (state_ff == RSAG_REQ) && bus_grant
                    && !bus_hold;
  assign done     = (state_ff == RSAG_COL);

  rsag_req_track u_req (
    .clk             (clk),
    .rst_n           (rst_sync_ff),
    .hblank_start    (hblank_start),
    .vblank          (vblank),
    .first_line_next (first_line_next),
    .done            (done),
    .pending         (pending)
  );

  assign af.counter       = cnt;
  assign af.origin_select = origin_sel;
  assign af.pan_tap       = tap_ff[TAP_W-1:0];

  rsag_addr_fmt u_fmt (
    .af (af)
  );

  // Next state of the refresh cycle.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      RSAG_IDLE: begin
        if (pending) begin
          nxt_state = RSAG_REQ;
        end
      end
      RSAG_REQ: begin
        if (start_go) begin
          nxt_state = RSAG_ROW;
        end
      end
      RSAG_ROW: begin
        nxt_state = RSAG_COL;
      end
      RSAG_COL: begin
        nxt_state = RSAG_IDLE;
      end
      default: begin
        nxt_state = RSAG_IDLE;
      end
    endcase
  end

  // Counter update: reload first, then the step, then software.
  always_comb begin
    nxt_addr_cnt = addr_cnt_ff;
    if (reload) begin
      nxt_addr_cnt[CNT_LSB +: CNT_W] = reload_val;
    end else if (done) begin
      nxt_addr_cnt[CNT_LSB +: CNT_W] = stepped_val;
    end else if (wr_cnt && state_ff == RSAG_IDLE) begin
      nxt_addr_cnt = reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      state_ff    <= RSAG_IDLE;
      addr_cnt_ff <= ADDR_COUNTER_RST;
    end else begin
      state_ff    <= nxt_state;
      addr_cnt_ff <= nxt_addr_cnt;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      ctrl_ff  <= CTRL_RST;
      start_ff <= FRAME_START_RST;
      tap_ff   <= PAN_TAP_RST;
    end else begin
      ctrl_ff  <= wr_ctrl ? reg_wdata : ctrl_ff;
      start_ff <= wr_start ? reg_wdata : start_ff;
      tap_ff   <= wr_tap ? reg_wdata : tap_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  // Local bus address word: row, then column, then released.
  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      bus_word_ff <= 16'h0000;
      bus_oe_ff   <= 1'b0;
    end else if (start_go) begin
      bus_word_ff <= af.row_word;
      bus_oe_ff   <= 1'b1;
    end else if (state_ff == RSAG_ROW) begin
      bus_word_ff <= af.col_word;
      bus_oe_ff   <= 1'b1;
    end else begin
      bus_word_ff <= 16'h0000;
      bus_oe_ff   <= 1'b0;
    end
  end

  assign reg_rdata     = rdata_ff;
  assign srf_req       = (state_ff == RSAG_REQ);
  assign row_phase     = (state_ff == RSAG_ROW);
  assign col_phase     = (state_ff == RSAG_COL);
  assign local_bus_out = bus_word_ff;
  assign local_bus_oe  = bus_oe_ff;

  // Checks.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_sync_ff);

  a_req_on_hblank: assert property (
    hblank_start && !vblank |=> pending)
    else $error("refresh request not raised at blanking");

  a_vblank_quiet: assert property (
    state_ff == RSAG_IDLE && !pending && hblank_start && vblank
    && !first_line_next |=> !pending)
    else $error("refresh request during vertical blanking");

  a_row_word_out: assert property (
    row_phase |-> local_bus_out[11:0] == ($past(origin_sel) ?
      $past(cnt[CNT_W-1:2]) : ~$past(cnt[CNT_W-1:2])))
    else $error("row address bits wrong");

  a_row_status: assert property (
    row_phase |-> local_bus_out[15:12] == 4'h8 && local_bus_oe)
    else $error("row status lines wrong");

  a_col_merge: assert property (
    col_phase && !$past(reload) |-> local_bus_out[10:6] ==
      (tap_ff[10:6] | (origin_sel ? $past(cnt[4:0])
                                  : ~$past(cnt[4:0]))))
    else $error("column merge wrong");

  a_col_fixed: assert property (
    col_phase |-> local_bus_out[5:0] == tap_ff[5:0]
      && local_bus_out[13:12] == tap_ff[13:12]
      && local_bus_out[15:14] == 2'h0)
    else $error("column tap or status wrong");

  a_row_then_col: assert property (
    srf_req && bus_grant && !bus_hold |=> row_phase ##1 col_phase
      ##1 !local_bus_oe)
    else $error("row and column phases out of order");

  a_hold_waits: assert property (
    srf_req && bus_hold |=> !row_phase && srf_req)
    else $error("refresh cycle started under hold");

  a_line_step: assert property (
    col_phase && !reload |=> cnt == $past(cnt) - $past(step_ext))
    else $error("counter not stepped after column phase");

  a_frame_reload: assert property (
    reload |=> cnt == $past(reload_val))
    else $error("frame reload wrong");

  a_even_half: assert property (
    reload && !nonint_sel && even_field |=>
      cnt == $past(start_ff[CNT_LSB +: CNT_W]) + $past(half_ext))
    else $error("even field offset missing");

  a_col_top_bit: assert property (
    col_phase |-> local_bus_out[11] == ($past(tap_ff[11]) |
      ($past(origin_sel) ? $past(cnt[5]) : ~$past(cnt[5]))))
    else $error("column bit eleven wrong");

  a_bus_released: assert property (
    !row_phase && !col_phase |-> !local_bus_oe && local_bus_out == 16'h0000)
    else $error("local bus driven outside a refresh cycle");

  a_req_held: assert property (
    srf_req && !(bus_grant && !bus_hold) |=> srf_req)
    else $error("refresh request dropped before grant");

  a_one_row: assert property (
    row_phase |=> col_phase && !row_phase)
    else $error("row phase not followed by column phase");

  a_col_after_row: assert property (
    col_phase |-> $past(row_phase))
    else $error("column phase without row phase");

  a_oe_with_phase: assert property (
    row_phase || col_phase |-> local_bus_oe)
    else $error("local bus not driven during address phase");

  a_cnt_steady: assert property (
    !done && !reload && !wr_cnt |=> cnt == $past(cnt))
    else $error("counter moved outside a step or reload");

  a_full_start: assert property (
    reload && (nonint_sel || !even_field) |=>
      cnt == $past(start_ff[CNT_LSB +: CNT_W]))
    else $error("reload offset applied outside even field");

  a_no_hblank_req: assert property (
    !pending && !hblank_start |=> !pending)
    else $error("refresh request raised without blanking");

  a_srf_from_pending: assert property (
    state_ff == RSAG_IDLE && pending |=> srf_req)
    else $error("pending request not presented");

  c_full_cycle: cover property (
    srf_req ##1 row_phase ##1 col_phase);
  c_hold_delay: cover property (
    srf_req && bus_hold ##1 srf_req ##[1:20] row_phase);
  c_reload_even: cover property (
    reload && even_field && !nonint_sel);
  c_origin_one: cover property (row_phase && origin_sel);
  c_nonint_reload: cover property (reload && nonint_sel);

endmodule

`default_nettype wire

// ---- sim/rsag_vram_model.sv ----
`timescale 1ns/10ps
`default_nettype none

// Memory controller and VRAM side: grants the bus after a set wait.
module rsag_vram_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       srf_req,
  input  wire logic [3:0] wait_cycles,
  output logic            bus_grant
);
  logic [3:0] wait_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_ff   <= 4'h0;
      bus_grant <= 1'b0;
    end else if (!srf_req) begin
      wait_ff   <= 4'h0;
      bus_grant <= 1'b0;
    end else if (wait_ff >= wait_cycles) begin
      bus_grant <= 1'b1;
    end else begin
      wait_ff <= wait_ff + 4'h1;
    end
  end
endmodule

`default_nettype wire

// ---- sim/vram_screen_refresh_addr_gen_test.sv ----
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end

module vram_screen_refresh_addr_gen_test;
  import rsag_pkg::*;
  logic              clk, rst_n, reg_wr, reg_rd, hblank_start, frame_end;
  logic              vblank, first_line_next, even_field, bus_grant;
  logic              bus_hold, srf_req, row_phase, col_phase, local_bus_oe;
  logic              rd_seen, orig, nonint, ev;
  logic [REG_DW-1:0] exp_r;
  logic [REG_AW-1:0] reg_addr;
  logic [REG_DW-1:0] reg_wdata, reg_rdata, ctrl, start, tap;
  logic [LBUS_W-1:0] local_bus_out, exp_l;
  logic [CNT_W-1:0]  cnt;
  logic [7:0]        step;
  logic [3:0]        wait_cycles;
  logic [31:0]       r;
  logic [REG_DW-1:0] rq[$];
  logic [LBUS_W-1:0] lq[$];
  int                bad_count, n_tests, n_cols, n_rows, seed, c;
  event              hang;

  rsag_refresh_addr_gen dut_u (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .hblank_start, .frame_end, .vblank, .first_line_next,
    .even_field, .bus_grant, .bus_hold, .srf_req, .row_phase, .col_phase,
    .local_bus_out, .local_bus_oe);

  rsag_vram_model vram_u (.clk, .rst_n, .srf_req, .wait_cycles, .bus_grant);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (rst_n === 1'b1) begin
      if (rd_seen === 1'b1) begin
        exp_r = rq.pop_front();
        `CHK("reg_rdata", exp_r, reg_rdata)
      end
      if (row_phase === 1'b1 || col_phase === 1'b1) begin
        `CHK("bus_oe", 1'b1, local_bus_oe)
        exp_l = lq.pop_front();
        `CHK("bus_word", exp_l, local_bus_out)
        if (row_phase === 1'b1) n_rows++;
        else n_cols++;
        `CHK("row_before_col", n_rows, n_cols + (col_phase ? 0 : 1))
      end else `CHK("bus_idle", 17'h0, {local_bus_oe, local_bus_out})
    end
    rd_seen <= reg_rd;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] e);
    rq.push_back(e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
  endtask

  task automatic hb(input logic fe, input logic vb, input logic fl,
                    input logic evf);
    @(posedge clk);
    hblank_start    <= 1'b1;
    frame_end       <= fe;
    vblank          <= vb;
    first_line_next <= fl;
    even_field      <= evf;
    @(posedge clk);
    hblank_start    <= 1'b0;
  endtask

  task automatic refresh(input logic vb, input logic fl);
    logic [5:0] a;
    int         c0;
    c0 = n_cols;
    a  = orig ? cnt[5:0] : ~cnt[5:0];
    lq.push_back({4'h8, orig ? cnt[13:2] : ~cnt[13:2]});
    lq.push_back({2'b00, tap[13:12], tap[11:6] | a, tap[5:0]});
    hb(1'b0, vb, fl, 1'b0);
    for (int w = 0; w < 60 && n_cols == c0; w++) @(posedge clk);
    if (n_cols == c0) begin
      bad_count++;
      -> hang;
    end
    cnt = cnt - {6'h00, step};
  endtask

  task automatic wrap_up();
    if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    @(hang);
    wrap_up();
  end

  initial begin
    seed = 32'h924a;
    {reg_wr, reg_rd, hblank_start, frame_end, vblank} = 5'h00;
    {first_line_next, even_field, bus_hold, rd_seen} = 4'h0;
    reg_addr = 2'h0;
    reg_wdata = 16'h0000;
    wait_cycles = 4'h0;
    rst_n = 1'b0;
    tick(8);
    rst_n <= 1'b1;
    tick(3);
    for (int j = 0; j < 4; j++) rd(j[1:0], 16'h0000);
    hb(1'b0, 1'b1, 1'b0, 1'b0);
    tick(6);
    `CHK("srf_req_vblank", 1'b0, srf_req)
    for (int i = 0; i < 8; i++) begin
      orig = i[0];
      nonint = i[1];
      ev = i[2];
      step = 8'h01 << i;
      r = $random(seed);
      wait_cycles <= {2'b00, r[1:0]};
      ctrl = {4'h0, nonint, orig, step, 2'b00};
      r = $random(seed);
      start = {r[15:2], 2'b00};
      r = $random(seed);
      tap = {2'b00, r[13:0]};
      wr(CTRL_OFS, ctrl);
      wr(FRAME_START_OFS, start);
      wr(PAN_TAP_OFS, tap);
      rd(CTRL_OFS, ctrl);
      rd(PAN_TAP_OFS, tap);
      rd(FRAME_START_OFS, start);
      hb(1'b1, 1'b1, 1'b0, ev);
      cnt = start[15:2] +
            ((!nonint && ev) ? {7'h00, step[7:1]} : 14'h0);
      rd(ADDR_COUNTER_OFS, {cnt, 2'b00});
      refresh(1'b1, 1'b1);
      c = n_rows;
      @(posedge clk);
      bus_hold <= (i == 3);
      fork
        refresh(1'b0, 1'b0);
        begin
          tick(20);
          `CHK("srf_req_hold", (i == 3), srf_req)
          `CHK("rows_in_hold", c + ((i == 3) ? 0 : 1), n_rows)
          bus_hold <= 1'b0;
        end
      join
      rd(ADDR_COUNTER_OFS, {cnt, 2'b00});
    end
    r = $random(seed);
    wr(ADDR_COUNTER_OFS, r[15:0]);
    rd(ADDR_COUNTER_OFS, r[15:0]);
    cnt = r[15:2];
    refresh(1'b0, 1'b0);
    rd(ADDR_COUNTER_OFS, {cnt, r[1:0]});
    tick(3);
    wrap_up();
  end
endmodule

`default_nettype wire
